// File: pkg/fsl_pkg.sv
/*
  fsl_pkg: register map, field positions and reset values of the fan speed
  status and limit block. Assumes a 32-bit plain register port, 100 MHz mclk.
*/
package fsl_pkg;
  localparam int          FSL_AW          = 8;
  localparam int          FSL_DW          = 32;
  localparam int          FSL_CW          = 16;
  // offsets
  localparam logic [7:0]  FSL_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  FSL_OFS_FLAGS   = 8'h04;
  localparam logic [7:0]  FSL_OFS_UPPER   = 8'h08;
  localparam logic [7:0]  FSL_OFS_LOWER   = 8'h0C;
  // flag bit positions
  localparam int          FSL_B_RANGE     = 0;
  localparam int          FSL_B_LEVEL     = 1;
  localparam int          FSL_B_EDGE      = 2;
  localparam int          FSL_B_READY     = 3;
  localparam int          FSL_NFLAG       = 4;
  // control bit positions
  localparam int          FSL_B_RANGE_EN  = 0;
  localparam int          FSL_B_EDGE_EN   = 1;
  localparam int          FSL_B_READY_EN  = 2;
  localparam int          FSL_B_MODE      = 3;
  // reset values
  localparam logic [15:0] FSL_UPPER_RST   = 16'hFFFF;
  localparam logic [15:0] FSL_LOWER_RST   = 16'h0000;
  localparam logic [3:0]  FSL_CTRL_RST    = 4'h0;
  localparam logic [31:0] FSL_ZERO        = 32'h0000_0000;
endpackage

// File: pkg/fsl_cmp_if.sv
/*
  fsl_cmp_if: carries the speed count and the two bounds into the range
  comparator and its verdict back. Assumes a single mclk domain.
*/
`timescale 1ns/1ps
interface fsl_cmp_if;
  logic [15:0] speed_count_value;
  logic [15:0] upper_bound;
  logic [15:0] lower_count_bound;
  logic        outside;
  modport ctl (output speed_count_value, output upper_bound,
               output lower_count_bound, input outside);
  modport cmp (input speed_count_value, input upper_bound,
               input lower_count_bound, output outside);
endinterface

// File: verilog/fsl_range_cmp.sv
/*
  fsl_range_cmp: compares the speed count with the upper and lower bounds.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
module fsl_range_cmp
  import fsl_pkg::*;
(
  fsl_cmp_if.cmp c
);
  // a zero lower bound can never trip since nothing is below zero
  assign c.outside = (c.speed_count_value > c.upper_bound) ||
                     (c.speed_count_value < c.lower_count_bound);
endmodule

// File: verilog/fsl_top.sv
/*
  fsl_top: fan speed status flags, level, ready, bounds and one interrupt.
  Assumes the counter datapath outside supplies speed_count_value and a
  one-cycle count_latched pulse on mclk; fan_in is an asynchronous pin.
*/
// Our own choice: the address-and-strobe port.
// How it works
// - ready flag stays zero while the reading-method select is zero, except in the first cycle after it drops.
// - in reference-clock mode a latched count sets the ready flag.
// - edge and range flags clear only on a written one; ready also clears while the reading-method select is zero.
// - enabled ready flag raises the interrupt.
// - every fan input level change held for two or more mclk cycles, rising or falling, sets the edge flag.
// - enabled edge flag raises the interrupt.
// - read-only level bit mirrors the fan input.
// - count above upper or below lower bound sets the range flag.
// - enabled range flag raises the interrupt.
// - upper bound is read/write, resets to all ones.
// - a static fan input level never sets the edge flag.
// - reference mode latches and restarts the count after programmed edges; this block holds no counter or edge setting and only takes count_latched.
// - count below the lower bound sets the range flag.
// - lower bound zero disables the below event, and is its reset value.
`timescale 1ns/1ps
module fsl_top
  import fsl_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [FSL_AW-1:0] reg_addr,
  input  wire logic [FSL_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [FSL_DW-1:0] reg_rdata,
  input  wire logic              fan_in,
  input  wire logic [FSL_CW-1:0] speed_count_value,
  input  wire logic              count_latched,
  output logic                   read_mode_sel,
  output logic                   irq
);
  logic [2:0]        fan_sync;
  logic              fan_level;
  logic [3:0]        ctrl;
  logic [FSL_CW-1:0] upper_bound;
  logic [FSL_CW-1:0] lower_count_bound;
  logic              ready_flag;
  logic              edge_flag;
  logic              range_violation_flag;
  logic              next_irq;
  logic              wr_ctrl;
  logic              wr_flags;
  logic              in_changed;
  logic [FSL_DW-1:0] next_rdata;
  logic [2:0]        sync_fill;
  logic              sync_settled;
  logic              seed_now;
  logic              level_seeded;
  logic              hit_ctrl;
  logic              hit_flags;
  logic              hit_upper;
  logic              hit_lower;
  logic              wr_upper;
  logic              wr_lower;
  logic              range_violation_irq_en;
  logic              edge_irq_en;
  logic              ready_irq_en;
  logic              mode_ref;
  logic              set_range;
  logic              set_edge;
  logic              set_ready;
  logic              clr_range;
  logic              clr_edge;
  logic              clr_ready;
  logic [2:0]        irq_cause;
  logic [FSL_DW-1:0] ctrl_word;
  logic [FSL_DW-1:0] flags_word;
  logic [FSL_DW-1:0] upper_word;
  logic [FSL_DW-1:0] lower_word;

  fsl_cmp_if cif ();
  assign cif.speed_count_value = speed_count_value;
  assign cif.upper_bound       = upper_bound;
  assign cif.lower_count_bound = lower_count_bound;

  fsl_range_cmp u_cmp (
    .c (cif.cmp)
  );

  // one decode per register; unmapped addresses match none and are ignored
  assign hit_ctrl  = (reg_addr == FSL_OFS_CTRL);
  assign hit_flags = (reg_addr == FSL_OFS_FLAGS);
  assign hit_upper = (reg_addr == FSL_OFS_UPPER);
  assign hit_lower = (reg_addr == FSL_OFS_LOWER);
  assign wr_ctrl   = reg_wr && hit_ctrl;
  assign wr_flags  = reg_wr && hit_flags;
  assign wr_upper  = reg_wr && hit_upper;
  assign wr_lower  = reg_wr && hit_lower;

  // named views of the control fields
  assign range_violation_irq_en = ctrl[FSL_B_RANGE_EN];
  assign edge_irq_en            = ctrl[FSL_B_EDGE_EN];
  assign ready_irq_en           = ctrl[FSL_B_READY_EN];
  assign mode_ref               = ctrl[FSL_B_MODE];

  // event sources and write-one-clear strobes of the sticky flags
  assign set_range = cif.outside;
  assign set_edge  = in_changed;
  assign set_ready = mode_ref && count_latched;
  assign clr_range = wr_flags && reg_wdata[FSL_B_RANGE];
  assign clr_edge  = wr_flags && reg_wdata[FSL_B_EDGE];
  assign clr_ready = wr_flags && reg_wdata[FSL_B_READY];

  // three stages; a change counts only once stages two and three agree and differ from the held level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fan_sync <= 3'b000;
    end else begin
      fan_sync <= {fan_sync[1:0], fan_in};
    end
  end

  // marks which stages already hold a real pin sample since reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_fill <= 3'h0;
    end else begin
      sync_fill <= {sync_fill[1:0], 1'b1};
    end
  end

  assign sync_settled = (fan_sync[1] == fan_sync[2]);

  // the first settled sample only seeds the level: a pin already held high
  // at reset (locked rotor) must not look like an edge
  assign seed_now = sync_fill[2] && !level_seeded && sync_settled;

  // set once per reset; afterwards only real transitions move the level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      level_seeded <= 1'b0;
    end else if (seed_now) begin
      level_seeded <= 1'b1;
    end
  end

  // stable level kept apart from the chain so a static pin makes no edge
  assign in_changed = level_seeded && sync_settled && (fan_sync[2] != fan_level);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fan_level <= 1'b0;
    end else if (seed_now || in_changed) begin
      fan_level <= fan_sync[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= FSL_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata[FSL_B_MODE:0];
    end
  end

  // handed on with the write itself, so datapath and ctrl switch together; the ready flag clears one cycle later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      read_mode_sel <= 1'b0;
    end else begin
      read_mode_sel <= (wr_ctrl) ? reg_wdata[FSL_B_MODE] : ctrl[FSL_B_MODE];
    end
  end

  // a bound moved past the live count raises the range flag on the next edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      upper_bound <= FSL_UPPER_RST;
    end else if (wr_upper) begin
      upper_bound <= reg_wdata[FSL_CW-1:0];
    end
  end

  // zero here means no below-bound event can ever fire
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lower_count_bound <= FSL_LOWER_RST;
    end else if (wr_lower) begin
      lower_count_bound <= reg_wdata[FSL_CW-1:0];
    end
  end

  // sticky flags: a set in the same cycle as a write-one clear wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready_flag <= 1'b0;
    end else if (!mode_ref) begin
      ready_flag <= 1'b0;
    end else if (set_ready) begin
      ready_flag <= 1'b1;
    end else if (clr_ready) begin
      ready_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      edge_flag <= 1'b0;
    end else if (set_edge) begin
      edge_flag <= 1'b1;
    end else if (clr_edge) begin
      edge_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      range_violation_flag <= 1'b0;
    end else if (set_range) begin
      range_violation_flag <= 1'b1;
    end else if (clr_range) begin
      range_violation_flag <= 1'b0;
    end
  end

  // one cause bit per enable; the level stays up while any cause does
  always_comb begin
    irq_cause                 = '0;
    irq_cause[FSL_B_RANGE_EN] = range_violation_flag && range_violation_irq_en;
    irq_cause[FSL_B_EDGE_EN]  = edge_flag && edge_irq_en;
    irq_cause[FSL_B_READY_EN] = ready_flag && ready_irq_en;
    next_irq                  = |irq_cause;
  end

  // registered, so irq lags the flag by one cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // reserved bits always read as zero
  always_comb begin
    ctrl_word               = FSL_ZERO;
    ctrl_word[FSL_B_MODE:0] = ctrl;
  end

  always_comb begin
    flags_word              = FSL_ZERO;
    flags_word[FSL_B_RANGE] = range_violation_flag;
    flags_word[FSL_B_LEVEL] = fan_level;
    flags_word[FSL_B_EDGE]  = edge_flag;
    flags_word[FSL_B_READY] = ready_flag;
  end

  always_comb begin
    upper_word             = FSL_ZERO;
    upper_word[FSL_CW-1:0] = upper_bound;
  end

  always_comb begin
    lower_word             = FSL_ZERO;
    lower_word[FSL_CW-1:0] = lower_count_bound;
  end

  always_comb begin
    next_rdata = FSL_ZERO;
    case (reg_addr)
      FSL_OFS_CTRL: begin
        next_rdata = ctrl_word;
      end
      FSL_OFS_FLAGS: begin
        next_rdata = flags_word;
      end
      FSL_OFS_UPPER: begin
        next_rdata = upper_word;
      end
      FSL_OFS_LOWER: begin
        next_rdata = lower_word;
      end
      default: begin
        next_rdata = FSL_ZERO;
      end
    endcase
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= FSL_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= FSL_ZERO;
    end
  end
endmodule

// File: verif/fsl_monitor.sv
/*
  fsl_monitor: port assertions for fsl_top.
  assumes one mclk domain with synchronous active-low rst_n.
*/
`timescale 1ns/1ps
module fsl_monitor
  import fsl_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [FSL_AW-1:0] reg_addr,
  input wire logic [FSL_DW-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [FSL_DW-1:0] reg_rdata,
  input wire logic              fan_in,
  input wire logic              count_latched,
  input wire logic              read_mode_sel,
  input wire logic              irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [2:0] en;
  // shadow of the enables, so irq is judged against what software wrote
  always_ff @(posedge mclk) begin
    if (!rst_n)
      en <= 3'h0;
    else if (reg_wr && reg_addr == FSL_OFS_CTRL)
      en <= reg_wdata[2:0];
  end
  sequence s_rd;
    reg_rd && reg_addr == FSL_OFS_FLAGS;
  endsequence
  property p_ready_off;
    s_rd ##0 (!read_mode_sel && !$past(read_mode_sel)) |=> !reg_rdata[3];
  endproperty
  property p_ready_set;
    (read_mode_sel && count_latched && !reg_wr) ##1 s_rd ##0 read_mode_sel |=> reg_rdata[3];
  endproperty
  property p_sticky;
    s_rd ##1 (reg_rdata[2] && !reg_wr) ##1 s_rd |=> reg_rdata[2];
  endproperty
  property p_irq_ready;
    s_rd ##1 (reg_rdata[3] && en[2]) |-> irq;
  endproperty
  property p_irq_edge;
    s_rd ##1 (reg_rdata[2] && en[1]) |-> irq;
  endproperty
  property p_irq_range;
    s_rd ##1 (reg_rdata[0] && en[0]) |-> irq;
  endproperty
  property p_irq_none;
    s_rd ##1 ((reg_rdata[3:0] & {en[2], en[1], 1'b0, en[0]}) == 4'h0) |-> !irq;
  endproperty
  // eight quiet cycles cover the pin synchroniser delay
  property p_level;
    $stable(fan_in)[*8] ##0 s_rd |=> reg_rdata[1] == $past(fan_in);
  endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready set in edge mode");
  a_ready_set: assert property (p_ready_set) else $error("ready not set on latch");
  a_sticky: assert property (p_sticky) else $error("edge flag lost");
  a_irq_ready: assert property (p_irq_ready) else $error("irq low on ready");
  a_irq_edge: assert property (p_irq_edge) else $error("irq low on edge");
  a_irq_range: assert property (p_irq_range) else $error("irq low on range");
  a_irq_none: assert property (p_irq_none) else $error("irq without cause");
  a_level: assert property (p_level) else $error("level bit wrong");
endmodule
bind fsl_top fsl_monitor fsl_monitor_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fan_in(fan_in), .count_latched(count_latched), .read_mode_sel(read_mode_sel), .irq(irq));

// File: verif/fsl_fan_model.sv
/*
  fsl_fan_model: fan tach or locked-rotor pin.
  assumes the bench sets the level; a held level gives no edges.
*/
`timescale 1ns/1ps
module fsl_fan_model (
  input  wire logic mclk,
  input  wire logic level,
  output logic      fan_in
);
  always @(posedge mclk) begin
    fan_in <= level;
  end
endmodule

// File: verif/tb_fan_speed_status_and_limit.sv
/*
  tb_fan_speed_status_and_limit: register-level tests of fsl_top.
  assumes fsl_pkg, fsl_fan_model and a 100 MHz mclk.
*/
`timescale 1ns/1ps
module tb_fan_speed_status_and_limit
  import fsl_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        count_latched = 1'b0;
  logic        level = 1'b0;
  logic        fan_in;
  logic        irq;
  logic        read_mode_sel;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic [15:0] speed_count_value = 16'h0000;
  int          miscompares = 0;
  int          n_checks = 0;
  fsl_top fsl_top_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fan_in(fan_in), .speed_count_value(speed_count_value),
    .count_latched(count_latched), .read_mode_sel(read_mode_sel), .irq(irq));
  fsl_fan_model fsl_fan_model_inst (.mclk(mclk), .level(level), .fan_in(fan_in));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(what, exp, reg_rdata);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(FSL_OFS_FLAGS, 32'h0000_0000, "flags");
    rd(FSL_OFS_UPPER, 32'h0000_FFFF, "upper");
    rd(FSL_OFS_LOWER, 32'h0000_0000, "lower");
    rd(8'h10, 32'h0000_0000, "unmapped");
    wr(FSL_OFS_UPPER, 32'h0000_1234);
    rd(FSL_OFS_UPPER, 32'h0000_1234, "upper");
    $display("test bounds done");
    wr(FSL_OFS_CTRL, 32'h0000_0002);
    level <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(FSL_OFS_FLAGS, 32'h0000_0006, "flags");
    wr(FSL_OFS_FLAGS, 32'h0000_0000);
    rd(FSL_OFS_FLAGS, 32'h0000_0006, "flags");
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(FSL_OFS_FLAGS, 32'h0000_0004);
    repeat (20) @(posedge mclk);
    rd(FSL_OFS_FLAGS, 32'h0000_0002, "flags");
    chk("irq", 32'h0000_0000, 32'(irq));
    level <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(FSL_OFS_FLAGS, 32'h0000_0004, "flags");
    rd(FSL_OFS_FLAGS, 32'h0000_0004, "flags");
    wr(FSL_OFS_FLAGS, 32'h0000_0004);
    $display("test edges done");
    speed_count_value <= 16'h2000;
    wr(FSL_OFS_CTRL, 32'h0000_0001);
    rd(FSL_OFS_FLAGS, 32'h0000_0001, "flags");
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(FSL_OFS_UPPER, 32'h0000_FFFF);
    wr(FSL_OFS_FLAGS, 32'h0000_0001);
    rd(FSL_OFS_FLAGS, 32'h0000_0000, "flags");
    wr(FSL_OFS_LOWER, 32'h0000_3000);
    rd(FSL_OFS_FLAGS, 32'h0000_0001, "flags");
    $display("test range done");
    wr(FSL_OFS_LOWER, 32'h0000_0000);
    wr(FSL_OFS_CTRL, 32'h0000_0004);
    chk("mode", 32'h0000_0000, 32'(read_mode_sel));
    wr(FSL_OFS_FLAGS, 32'h0000_0001);
    count_latched <= 1'b1;
    @(posedge mclk);
    count_latched <= 1'b0;
    rd(FSL_OFS_FLAGS, 32'h0000_0000, "flags");
    wr(FSL_OFS_CTRL, 32'h0000_000C);
    chk("mode", 32'h0000_0001, 32'(read_mode_sel));
    count_latched <= 1'b1;
    @(posedge mclk);
    count_latched <= 1'b0;
    rd(FSL_OFS_FLAGS, 32'h0000_0008, "flags");
    chk("irq", 32'h0000_0001, 32'(irq));
    $display("test ready done");
    level <= 1'b1;
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    wr(FSL_OFS_CTRL, 32'h0000_0002);
    repeat (10) @(posedge mclk);
    rd(FSL_OFS_FLAGS, 32'h0000_0002, "flags");
    chk("irq", 32'h0000_0000, 32'(irq));
    $display("test reset done");
    conclude();
  end
endmodule
